//--- design/bpio_pkg.sv
// Package of constants for the parallel I/O card logic
package bpio_pkg;
	localparam int unsigned CLK_HZ = 50_000_000;
	localparam int unsigned WD_MS_MIN = 1;
	localparam int unsigned WD_MS_FACTORY = 1000;
	localparam int unsigned WD_MS_MAX = 16500;
	localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
	localparam int unsigned WD_MIN_CYC = WD_MS_MIN * CYC_PER_MS;
	localparam int unsigned WD_FACTORY_CYC = WD_MS_FACTORY * CYC_PER_MS;
	localparam int unsigned WD_MAX_CYC = WD_MS_MAX * CYC_PER_MS;
	localparam int unsigned WD_CNT_W = 30;
	localparam int unsigned WD_PULSE_CYC = 16;
	localparam int unsigned NUM_DEV = 4;
	localparam int unsigned REGS_PER_DEV = 4;
	localparam int unsigned NUM_REGS = 16;
	localparam int unsigned PORTS_PER_DEV = 3;
	localparam int unsigned LINES = 96;
	localparam int unsigned ADDR_W = 20;
	localparam int unsigned SEL_BITS_8 = 8;
	localparam logic [3:0] WAIT_3 = 4'h3;
	localparam logic [3:0] WAIT_5 = 4'h5;
	localparam logic [3:0] WAIT_8 = 4'h8;
	localparam logic [1:0] WSEL_3 = 2'h0;
	localparam logic [1:0] WSEL_5 = 2'h1;
	localparam logic [1:0] WSEL_8 = 2'h2;
	localparam logic [3:0] REG_WD_RETRIG = 4'hc;
	localparam logic [3:0] REG_WD_CTRL = 4'hd;
	localparam logic [3:0] REG_WD_STAT = 4'he;
	localparam logic [7:0] CTRL_RESET = 8'h9b;
	localparam logic [7:0] CTRL_ENABLE_BIT = 8'h80;
	localparam logic [7:0] DIR_ALL_IN = 8'h00;
endpackage

//--- design/bpio_wait_gen.sv
// Wait-state generator: holds the bus wait line for a jumpered count
module bpio_wait_gen import bpio_pkg::*; (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	// Configuration jumpers
	input wire logic wait_en,
	input wire logic [1:0] wait_sel,
	// Access
	input wire logic access,
	output logic wait_n
);
	logic [3:0] cnt_q, cnt_d;
	logic busy_q, busy_d;
	logic done_q, done_d;
	logic [3:0] target;
	logic start;

	assign target = (wait_sel == WSEL_3) ? WAIT_3 : (wait_sel == WSEL_5) ? WAIT_5 : WAIT_8;
	assign start = access && wait_en && !busy_q && !done_q;
	// The start cycle is the first wait state, so the counter holds the remaining ones
	assign busy_d = start ? 1'b1 : (busy_q && cnt_q == 4'h1) ? 1'b0 : busy_q;
	assign cnt_d = start ? target - 4'h1 : (busy_q && cnt_q != 4'h0) ? cnt_q - 4'h1 : 4'h0;
	// Stay done until the strobe drops so one access gets one stretch
	assign done_d = done_q || start;
	assign wait_n = !(start || busy_q);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= 4'h0;
			busy_q <= 1'b0;
			done_q <= 1'b0;
		end else if (ce) begin
			cnt_q <= access ? cnt_d : 4'h0;
			busy_q <= access ? busy_d : 1'b0;
			done_q <= access ? done_d : 1'b0;
		end
	end

	property p_wait_len;
		@(posedge clk) disable iff (!rst_n || !ce)
		$rose(busy_q) && wait_sel == WSEL_3 && access |-> busy_q [*2] ##1 !busy_q;
	endproperty
	a_wait_len: assert property (p_wait_len) else $error("three-wait stretch wrong");

	property p_wait_off;
		@(posedge clk) disable iff (!rst_n)
		!wait_en && !busy_q |-> wait_n;
	endproperty
	a_wait_off: assert property (p_wait_off) else $error("wait asserted while disabled");
endmodule

//--- design/bpio_watchdog.sv
// Watchdog timer with astable and monostable modes and a host reset pulse
module bpio_watchdog import bpio_pkg::*; #(
	parameter int unsigned MAX_CYC = WD_MAX_CYC,
	parameter int unsigned PULSE_CYC = WD_PULSE_CYC
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	// Control
	input wire logic enable,
	input wire logic astable,
	input wire logic [WD_CNT_W-1:0] interval,
	input wire logic retrig,
	// Status
	output logic host_reset_n,
	output logic fired
);
	logic [WD_CNT_W-1:0] cnt_q;
	logic [WD_CNT_W-1:0] lim;
	logic [7:0] pulse_q;
	logic fired_q;
	logic expire;

	// Clamp the interval into the legal window
	assign lim = (interval < WD_CNT_W'(WD_MIN_CYC)) ? WD_CNT_W'(WD_MIN_CYC) :
		(interval > WD_CNT_W'(MAX_CYC)) ? WD_CNT_W'(MAX_CYC) : interval;
	assign expire = enable && (cnt_q >= lim - WD_CNT_W'(1)) && !(fired_q && !astable);
	assign host_reset_n = (pulse_q == 8'h00);
	assign fired = fired_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= '0;
			pulse_q <= 8'h00;
			fired_q <= 1'b0;
		end else if (ce) begin
			if (retrig || !enable) begin
				cnt_q <= '0;
				fired_q <= 1'b0;
			end else if (expire) begin
				cnt_q <= '0;
				fired_q <= 1'b1;
			end else if (!(fired_q && !astable)) begin
				cnt_q <= cnt_q + WD_CNT_W'(1);
			end
			if (expire && !retrig)
				pulse_q <= 8'(PULSE_CYC);
			else if (pulse_q != 8'h00)
				pulse_q <= pulse_q - 8'h01;
		end
	end

	property p_fire;
		@(posedge clk) disable iff (!rst_n || !ce)
		expire && !retrig |=> !host_reset_n;
	endproperty
	a_fire: assert property (p_fire) else $error("expiry gave no host reset");

	property p_retrig;
		@(posedge clk) disable iff (!rst_n || !ce)
		retrig |=> cnt_q == '0 && !fired_q;
	endproperty
	a_retrig: assert property (p_retrig) else $error("retrigger did not restart");

	property p_mono;
		@(posedge clk) disable iff (!rst_n || !ce)
		fired_q && !astable && !retrig && enable |=> $stable(cnt_q);
	endproperty
	a_mono: assert property (p_mono) else $error("monostable kept counting");
endmodule

//--- design/bpio_card.sv
// Top of the 96-line parallel I/O card: decode, selects, waits, watchdog, safe reset
module bpio_card import bpio_pkg::*; #(
	parameter int unsigned WD_MAX = WD_MAX_CYC,
	parameter int unsigned WD_DEFAULT = WD_FACTORY_CYC
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	// Backplane bus
	input wire logic [ADDR_W-1:0] bus_addr,
	input wire logic [7:0] bus_wdata,
	output logic [7:0] bus_rdata,
	output logic bus_rdata_oe,
	input wire logic iorq_n,
	input wire logic rd_n,
	input wire logic wr_n,
	output logic wait_n,
	output logic host_reset_n,
	// Switches and jumpers
	input wire logic [7:0] base_addr_switch_a,
	input wire logic [7:0] base_addr_switch_b,
	input wire logic wide_addr_mode,
	input wire logic wait_en,
	input wire logic [1:0] wait_sel,
	input wire logic wd_astable,
	// Port device selects and local bus
	output logic [NUM_DEV-1:0] dev_cs_n,
	output logic [1:0] dev_reg_sel,
	output logic dev_rd_n,
	output logic dev_wr_n,
	output logic [NUM_DEV-1:0] dev_reset,
	input wire logic [7:0] dev_rdata [NUM_DEV],
	// Line direction view from the port devices
	input wire logic [LINES-1:0] dev_line_oe,
	output logic [LINES-1:0] line_oe,
	// Header views of the first two sections
	input wire logic [LINES-1:0] dev_line_out,
	output logic [15:0] second_ports_sec12_header,
	output logic [15:0] sec1_first_third_header,
	output logic [15:0] sec2_first_third_header,
	// Watchdog status
	output logic wd_fired
);
	logic [ADDR_W-5:0] upper;
	logic [15:0] sw_val;
	logic match_narrow, match_wide, hit;
	logic io_rd, io_wr, access;
	logic [3:0] reg_idx;
	logic [1:0] dev_idx;
	logic wd_space;
	logic [NUM_DEV-1:0] cs_vec;
	logic wr_q;
	logic wr_edge;
	logic wd_en_q, wd_astable_sw_q;
	logic [WD_CNT_W-1:0] wd_interval_q;
	logic [1:0] wd_byte_q;
	logic [7:0] rdata_q;
	logic safe_q;
	logic retrig;
	logic wd_astable_eff;

	// Address decode against switch bank A, or against both switch banks in wide mode
	assign sw_val = {base_addr_switch_b, base_addr_switch_a};
	assign upper = bus_addr[ADDR_W-1:4];
	assign match_narrow = (upper[3:0] == sw_val[3:0]) && (sw_val[7:4] == 4'h0);
	assign match_wide = (upper[15:0] == sw_val);
	assign hit = wide_addr_mode ? match_wide : match_narrow;
	assign io_rd = !iorq_n && !rd_n;
	assign io_wr = !iorq_n && !wr_n;
	assign access = hit && (io_rd || io_wr);
	assign reg_idx = bus_addr[3:0];
	assign dev_idx = reg_idx[3:2];
	assign dev_reg_sel = reg_idx[1:0];
	// The last slot holds watchdog registers; the fourth device shares its data slots
	assign wd_space = (reg_idx == REG_WD_RETRIG) || (reg_idx == REG_WD_CTRL) || (reg_idx == REG_WD_STAT);

	generate
		for (genvar d = 0; d < NUM_DEV; d++) begin : g_cs
			assign cs_vec[d] = access && (dev_idx == 2'(d)) && !wd_space;
			assign dev_cs_n[d] = !cs_vec[d];
			assign dev_reset[d] = safe_q;
		end
	endgenerate

	assign dev_rd_n = !io_rd;
	assign dev_wr_n = !io_wr;
	assign wr_edge = io_wr && hit && !wr_q;

	// Watchdog registers: retrigger, control, interval bytes
	assign retrig = wr_edge && wd_space && (reg_idx == REG_WD_RETRIG);
	assign wd_astable_eff = wd_astable || wd_astable_sw_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_q <= 1'b0;
			wd_en_q <= 1'b0;
			wd_astable_sw_q <= 1'b0;
			wd_interval_q <= WD_CNT_W'(WD_DEFAULT);
			wd_byte_q <= 2'h0;
		end else if (ce) begin
			wr_q <= io_wr && hit;
			if (wr_edge && reg_idx == REG_WD_CTRL) begin
				wd_en_q <= bus_wdata[7];
				wd_astable_sw_q <= bus_wdata[6];
				wd_byte_q <= bus_wdata[1:0];
			end
			if (wr_edge && reg_idx == REG_WD_STAT) begin
				unique case (wd_byte_q)
					2'h0: wd_interval_q[7:0] <= bus_wdata;
					2'h1: wd_interval_q[15:8] <= bus_wdata;
					2'h2: wd_interval_q[23:16] <= bus_wdata;
					default: wd_interval_q[WD_CNT_W-1:24] <= bus_wdata[WD_CNT_W-25:0];
				endcase
			end
		end
	end

	// Read data comes from a flop that reloads on every enabled clock, one cycle behind the address and device data
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_q <= 8'h00;
		end else if (ce) begin
			if (reg_idx == REG_WD_CTRL)
				rdata_q <= {wd_en_q, wd_astable_eff, wd_fired, 3'h0, wd_byte_q};
			else if (wd_space)
				rdata_q <= {7'h00, !host_reset_n};
			else
				rdata_q <= dev_rdata[dev_idx];
		end
	end
	assign bus_rdata = rdata_q;
	assign bus_rdata_oe = hit && io_rd;

	// Hold the port devices in reset for one cycle after release so all lines float as inputs
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			safe_q <= 1'b1;
		else if (ce)
			safe_q <= 1'b0;
	end
	assign line_oe = safe_q ? {LINES{1'b0}} : dev_line_oe;

	// Header grouping of the first two sections
	// Each device owns 24 lines: first port [7:0], second [15:8], third [23:16]
	assign second_ports_sec12_header = {dev_line_out[39:32], dev_line_out[15:8]};
	assign sec1_first_third_header = {dev_line_out[23:16], dev_line_out[7:0]};
	assign sec2_first_third_header = {dev_line_out[47:40], dev_line_out[31:24]};

	bpio_wait_gen u_wait (
		.clk(clk),
		.rst_n(rst_n),
		.ce(ce),
		.wait_en(wait_en),
		.wait_sel(wait_sel),
		.access(access),
		.wait_n(wait_n)
	);

	bpio_watchdog #(
		.MAX_CYC(WD_MAX),
		.PULSE_CYC(WD_PULSE_CYC)
	) u_wd (
		.clk(clk),
		.rst_n(rst_n),
		.ce(ce),
		.enable(wd_en_q),
		.astable(wd_astable_eff),
		.interval(wd_interval_q),
		.retrig(retrig),
		.host_reset_n(host_reset_n),
		.fired(wd_fired)
	);

	property p_cs_qual;
		@(posedge clk) disable iff (!rst_n)
		!(&dev_cs_n) |-> !iorq_n && (!rd_n || !wr_n) && hit;
	endproperty
	a_cs_qual: assert property (p_cs_qual) else $error("select without strobes");

	property p_cs_onehot;
		@(posedge clk) disable iff (!rst_n)
		$onehot0(~dev_cs_n);
	endproperty
	a_cs_onehot: assert property (p_cs_onehot) else $error("more than one device selected");

	property p_safe;
		@(posedge clk) disable iff (!rst_n)
		safe_q |-> line_oe == '0;
	endproperty
	a_safe: assert property (p_safe) else $error("line driven during reset hold");

	property p_cs_idx;
		@(posedge clk) disable iff (!rst_n)
		access && !wd_space |-> !dev_cs_n[bus_addr[3:2]];
	endproperty
	a_cs_idx: assert property (p_cs_idx) else $error("wrong device selected");

	property p_wait_start;
		@(posedge clk) disable iff (!rst_n || !ce)
		$rose(access) && wait_en |-> !wait_n;
	endproperty
	a_wait_start: assert property (p_wait_start) else $error("no wait on access");

	property p_retrig_clear;
		@(posedge clk) disable iff (!rst_n || !ce)
		retrig |=> !wd_fired;
	endproperty
	a_retrig_clear: assert property (p_retrig_clear) else $error("retrigger ignored");
endmodule

//--- testbench/bpio_host_model.sv
// Host processor card model issuing byte reads and writes on the backplane
module bpio_host_model import bpio_pkg::*; (
	// Clock and wait
	input wire logic clk,
	input wire logic wait_n,
	// Bus
	output logic [ADDR_W-1:0] bus_addr,
	output logic [7:0] bus_wdata,
	output logic iorq_n,
	output logic rd_n,
	output logic wr_n
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		bus_addr = '0;
		bus_wdata = 8'h00;
		iorq_n = 1'b1;
		rd_n = 1'b1;
		wr_n = 1'b1;
	end
	// Address settles a cycle ahead; strobes hold until wait is sampled high
	task automatic io(input logic [ADDR_W-1:0] a, input logic [7:0] d, input logic rd);
		bus_addr <= a;
		bus_wdata <= d;
		@(posedge clk);
		iorq_n <= 1'b0;
		rd_n <= !rd;
		wr_n <= rd;
		do @(posedge clk); while (wait_n !== 1'b1);
		iorq_n <= 1'b1;
		rd_n <= 1'b1;
		wr_n <= 1'b1;
		// Released data lines must not look like a still-valid byte
		bus_wdata <= ~d;
		@(posedge clk);
	endtask
endmodule

//--- testbench/tb_bpio_card.sv
// Self-checking bench for the parallel I/O card logic
module tb_bpio_card import bpio_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {logic chk; logic [7:0] d; logic [6:0] sel; logic [31:0] w;} bpio_note_s;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic wide_addr_mode = 1'b0;
	logic wait_en = 1'b0;
	logic [1:0] wait_sel = 2'h0;
	logic [7:0] sw_a, sw_b, bus_wdata, bus_rdata;
	logic [7:0] dev_rdata [NUM_DEV];
	logic [LINES-1:0] dev_line_oe, dev_line_out, line_oe;
	logic [ADDR_W-1:0] bus_addr;
	logic bus_rdata_oe, iorq_n, rd_n, wr_n, wait_n, host_reset_n, wd_fired;
	logic [NUM_DEV-1:0] dev_cs_n, dev_reset;
	logic [1:0] dev_reg_sel;
	logic [15:0] hdr_b, hdr_1, hdr_2;
	bpio_note_s notes[$];
	bpio_note_s cur;
	int miscompares = 0;
	int checks = 0;
	int cycles = 0;
	int wc = 0;
	logic [31:0] rng = 32'h50;
	function automatic logic [31:0] rnd();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return rng;
	endfunction
	function automatic logic [ADDR_W-1:0] ha(input logic [3:0] r);
		return wide_addr_mode ? {sw_b, sw_a, r} : {12'h000, sw_a[3:0], r};
	endfunction
	initial forever #10 clk = ~clk;
	bpio_card #(.WD_DEFAULT(WD_MIN_CYC)) bpio_card_i (.clk(clk), .rst_n(rst_n), .ce(1'b1), .bus_addr(bus_addr),
		.bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .bus_rdata_oe(bus_rdata_oe), .iorq_n(iorq_n), .rd_n(rd_n),
		.wr_n(wr_n), .wait_n(wait_n), .host_reset_n(host_reset_n), .base_addr_switch_a(sw_a),
		.base_addr_switch_b(sw_b), .wide_addr_mode(wide_addr_mode), .wait_en(wait_en), .wait_sel(wait_sel),
		.wd_astable(1'b0), .dev_cs_n(dev_cs_n), .dev_reg_sel(dev_reg_sel), .dev_rd_n(), .dev_wr_n(),
		.dev_reset(dev_reset), .dev_rdata(dev_rdata), .dev_line_oe(dev_line_oe), .line_oe(line_oe),
		.dev_line_out(dev_line_out), .second_ports_sec12_header(hdr_b), .sec1_first_third_header(hdr_1),
		.sec2_first_third_header(hdr_2), .wd_fired(wd_fired));
	bpio_host_model bpio_host_model_i (.clk(clk), .wait_n(wait_n), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
		.iorq_n(iorq_n), .rd_n(rd_n), .wr_n(wr_n));
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH %s expected %0h seen %0h", name, exp, seen);
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic acc(input logic [ADDR_W-1:0] a, input logic rd, input logic [7:0] d, input logic hit);
		bpio_note_s n;
		logic [3:0] r;
		r = a[3:0];
		n.w = !(hit && wait_en) ? 32'h0 : (wait_sel == WSEL_3) ? 32'(WAIT_3) : (wait_sel == WSEL_5) ? 32'(WAIT_5) : 32'(WAIT_8);
		n.chk = hit && rd && (r < REG_WD_RETRIG || r == 4'hf);
		n.sel = {(hit && (r < REG_WD_RETRIG || r == 4'hf)) ? ~(4'h1 << r[3:2]) : 4'hf, r[1:0], hit && rd};
		n.d = dev_rdata[r[3:2]];
		notes.push_back(n);
		bpio_host_model_i.io(a, d, rd);
	endtask
	// Waits for a host reset pulse and measures it; exp of zero means none may come
	task automatic fire(input int lim, input logic [31:0] exp);
		int k;
		k = 0;
		while (host_reset_n !== 1'b0 && k < lim) begin
			@(posedge clk);
			k++;
		end
		k = 0;
		while (host_reset_n === 1'b0 && k < 64) begin
			@(posedge clk);
			k++;
		end
		check("reset_len", 32'(k), exp);
	endtask
	always @(posedge clk) begin
		cycles++;
		if (cycles == 102000) begin
			miscompares++;
			report_and_stop();
		end
		if (!iorq_n && (!rd_n || !wr_n)) begin
			if (wait_n === 1'b0) begin
				wc++;
			end else begin
				cur = notes.pop_front();
				check("waits", 32'(wc), cur.w);
				check("selects", 32'({dev_cs_n, dev_reg_sel, bus_rdata_oe}), 32'(cur.sel));
				if (cur.chk) check("rdata", 32'(bus_rdata), 32'(cur.d));
				wc = 0;
			end
		end
	end
	initial begin
		sw_a = {4'h0, 4'(rnd())};
		sw_b = 8'(rnd());
		foreach (dev_rdata[i]) dev_rdata[i] = 8'(rnd());
		dev_line_oe = {rnd(), rnd(), rnd()};
		dev_line_out = {rnd(), rnd(), rnd()};
		repeat (10) @(posedge clk);
		check("reset", 32'({|line_oe, dev_reset, host_reset_n, wait_n}), 32'h3f);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		check("line_oe", 32'({line_oe != dev_line_oe, dev_reset}), 32'h0);
		check("hdr_b", 32'(hdr_b), 32'({dev_line_out[39:32], dev_line_out[15:8]}));
		check("hdr_ac", {hdr_1, hdr_2}, {dev_line_out[23:16], dev_line_out[7:0], dev_line_out[47:40], dev_line_out[31:24]});
		// Every register, every wait jumper combination
		for (int i = 0; i < 16; i++) begin
			wait_en <= i[2];
			wait_sel <= 2'(i);
			@(posedge clk);
			acc(ha(4'(i)), 1'b1, 8'h00, 1'b1);
			check("idle", 32'({dev_cs_n, wait_n, bus_rdata_oe}), 32'h3e);
		end
		acc(ha(4'h3) ^ 20'h00010, 1'b1, 8'h00, 1'b0);
		wide_addr_mode <= 1'b1;
		@(posedge clk);
		acc(ha(4'h5), 1'b1, 8'h00, 1'b1);
		acc(ha(4'h5) ^ 20'h80000, 1'b1, 8'h00, 1'b0);
		// The interval never goes below the one-millisecond floor, so two astable periods fill most of the run
		acc(ha(REG_WD_CTRL), 1'b0, CTRL_ENABLE_BIT | 8'h40, 1'b1);
		fire(WD_MIN_CYC + 100, 32'(WD_PULSE_CYC));
		check("fired", 32'(wd_fired), 32'h1);
		fire(WD_MIN_CYC + 100, 32'(WD_PULSE_CYC));
		acc(ha(REG_WD_CTRL), 1'b0, CTRL_ENABLE_BIT, 1'b1);
		fire(600, 32'h0);
		check("fired_hold", 32'(wd_fired), 32'h1);
		acc(ha(REG_WD_RETRIG), 1'b0, 8'h00, 1'b1);
		check("fired", 32'(wd_fired), 32'h0);
		for (int i = 0; i < 4; i++) begin
			acc(ha(REG_WD_RETRIG), 1'b0, 8'h00, 1'b1);
			fire(150, 32'h0);
		end
		report_and_stop();
	end
endmodule
